// *** boot_cmd.sv ***
`timescale 1ns/1ps
module boot_cmd
(
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire logic                bootMode,
    input  wire logic                serialRx,
    input  wire boot_cmd_pkg::byte_s rxByte,
    input  wire logic                txReady,
    output boot_cmd_pkg::byte_s      txByte,
    output logic [15:0]              bitPeriod,
    output logic                     rateLocked,
    output logic                     eraseStart,
    input  wire logic                eraseDone,
    output logic                     progMode,
    output logic [31:0]              selDevice,
    output logic                     devSelected
);
    import boot_cmd_pkg::*;

    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        RX_CMD  = 4'b0001,
        RX_SIZE = 4'b0010,
        RX_DATA = 4'b0100,
        RX_SUM  = 4'b1000
    } rx_state_e;

    boot_state_e state,    next_state;
    rx_state_e   rxState,  next_rxState;
    logic [7:0]  curCmd,   next_curCmd;
    logic [7:0]  remain,   next_remain;
    logic [7:0]  runSum,   next_runSum;
    logic [31:0] codeSr,   next_codeSr;
    logic [15:0] lowCnt,   next_lowCnt;
    logic        lowSeen,  next_lowSeen;
    logic [15:0] next_bitPeriod;
    logic        next_rateLocked;
    logic        next_eraseStart;
    logic        next_progMode;
    logic [31:0] next_selDevice;
    logic        next_devSelected;
    logic [7:0]  reply [REPLY_LEN];
    logic [7:0]  next_reply [REPLY_LEN];
    logic [3:0]  replyLen, next_replyLen;
    logic [3:0]  replyIdx, next_replyIdx;
    byte_s       bufIn;
    logic        bufReady;
    byte_s       bufOut;
    logic [7:0]  sumAll;
    logic [7:0]  inqSum;

    // ------------------------------------------------------------
    // reply queue toward transmitter
    // ------------------------------------------------------------
    byte_buffer txBuf
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .inByte   (bufIn),
        .inReady  (bufReady),
        .outByte  (bufOut),
        .outReady (txReady)
    );

    always_comb
    begin
        bufIn.valid = (replyIdx != replyLen);
        bufIn.data  = reply[replyIdx];
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        next_state       = state;
        next_rxState     = rxState;
        next_curCmd      = curCmd;
        next_remain      = remain;
        next_runSum      = runSum;
        next_codeSr      = codeSr;
        next_lowCnt      = lowCnt;
        next_lowSeen     = lowSeen;
        next_bitPeriod   = bitPeriod;
        next_rateLocked  = rateLocked;
        next_eraseStart  = 1'b0;
        next_progMode    = progMode;
        next_selDevice   = selDevice;
        next_devSelected = devSelected;
        next_reply       = reply;
        next_replyLen    = replyLen;
        next_replyIdx    = replyIdx;
        sumAll           = sum8(runSum, rxByte.data);
        inqSum = 8'(8'h00 - (RSP_DEV_INQ + INQ_SIZE + DEV_COUNT + NAME_CHARS
                 + DEV_CODE[31:24] + DEV_CODE[23:16] + DEV_CODE[15:8]
                 + DEV_CODE[7:0] + PROG_NAME[31:24] + PROG_NAME[23:16]
                 + PROG_NAME[15:8] + PROG_NAME[7:0]));

        if (bufIn.valid && bufReady)
            next_replyIdx = replyIdx + 4'd1;

        unique case (state)
            ST_RATE:
            begin
                // measure low period of sync byte on channel one
                if (!bootMode)
                begin
                    next_lowSeen = 1'b0;
                    next_lowCnt  = 16'h0000;
                end
                else if (!serialRx)                      // see R02 see R23
                begin
                    next_lowSeen = 1'b1;
                    if (lowCnt != 16'hFFFF)
                        next_lowCnt = lowCnt + 16'h0001;
                end
                else if (lowSeen)
                begin
                    // zero byte low time is start plus eight bits
                    next_bitPeriod  = 16'(lowCnt / 16'd9);   // see R02
                    next_rateLocked = 1'b1;
                    next_state      = ST_INQ;                // see R03
                end
            end
            ST_INQ, ST_PROG:
            begin
                if (rxByte.valid && replyIdx == replyLen)
                begin
                    next_runSum = sumAll;
                    unique case (rxState)
                        RX_CMD:
                        begin
                            next_curCmd = rxByte.data;
                            next_runSum = rxByte.data;
                            if (state == ST_PROG)
                            begin
                                if (rxByte.data == CMD_STAT_INQ) // see R19
                                begin
                                    next_reply[0] = RSP_ACK;
                                    next_replyLen = 4'd1;
                                    next_replyIdx = 4'd0;
                                end
                            end
                            else if (rxByte.data == CMD_DEV_INQ)
                            begin
                                next_reply[0]  = RSP_DEV_INQ;    // see R13
                                next_reply[1]  = INQ_SIZE;       // see R07
                                next_reply[2]  = DEV_COUNT;
                                next_reply[3]  = NAME_CHARS;
                                next_reply[4]  = DEV_CODE[31:24];
                                next_reply[5]  = DEV_CODE[23:16];
                                next_reply[6]  = DEV_CODE[15:8];
                                next_reply[7]  = DEV_CODE[7:0];
                                next_reply[8]  = PROG_NAME[31:24];
                                next_reply[9]  = PROG_NAME[23:16];
                                next_reply[10] = PROG_NAME[15:8];
                                next_reply[11] = PROG_NAME[7:0];
                                next_reply[12] = inqSum;         // see R06
                                next_replyLen  = 4'd13;
                                next_replyIdx  = 4'd0;
                            end
                            else if (rxByte.data == CMD_DEV_SEL
                                     || rxByte.data == CMD_CLK_SEL
                                     || rxByte.data == CMD_RATE_SEL)
                                next_rxState = RX_SIZE;          // see R14
                            else if (rxByte.data == CMD_TRANS)
                            begin
                                next_eraseStart = 1'b1;          // see R04
                                next_state      = ST_ERAS;
                            end
                            else if (rxByte.data == CMD_STAT_INQ
                                     || (rxByte.data >= CMD_CLK_INQ
                                     && rxByte.data <= CMD_UNIT_INQ))
                            begin
                                // single-byte inquiry, acknowledged
                                next_reply[0] = RSP_ACK;     // see R08 R20
                                next_replyLen = 4'd1;        // see R21 R22
                                next_replyIdx = 4'd0;
                            end
                        end
                        RX_SIZE:
                        begin
                            next_remain  = rxByte.data;          // see R07
                            next_rxState = (rxByte.data == 8'h00)
                                           ? RX_SUM : RX_DATA;
                        end
                        RX_DATA:
                        begin
                            next_codeSr = {codeSr[23:0], rxByte.data};
                            next_remain = remain - 8'h01;
                            if (remain == 8'h01)
                                next_rxState = RX_SUM;
                        end
                        RX_SUM:
                        begin
                            next_rxState  = RX_CMD;
                            next_replyIdx = 4'd0;
                            if (sumAll != 8'h00)                 // see R06
                            begin
                                next_reply[0] = RSP_DEV_ERR | (curCmd & 8'h01);
                                next_reply[1] = ERR_SUM;     // see R09 R24
                                next_replyLen = 4'd2;
                            end
                            else if (curCmd == CMD_DEV_SEL
                                     && codeSr != DEV_CODE)
                            begin
                                next_reply[0] = RSP_DEV_ERR;     // see R16
                                next_reply[1] = ERR_DEV;
                                next_replyLen = 4'd2;
                            end
                            else
                            begin
                                // each device selection overwrites the earlier
                                if (curCmd == CMD_DEV_SEL)
                                begin
                                    next_selDevice   = codeSr;   // see R18
                                    next_devSelected = 1'b1;     // see R15
                                end
                                next_reply[0] = RSP_ACK;
                                next_replyLen = 4'd1;
                            end
                        end
                        default:
                            next_rxState = RX_CMD;
                    endcase
                end
            end
            ST_ERAS:
            begin
                if (eraseDone)
                begin
                    next_progMode = 1'b1;                // see R04 R05
                    next_state    = ST_PROG;
                    next_reply[0] = RSP_ACK;
                    next_replyLen = 4'd1;
                    next_replyIdx = 4'd0;
                end
            end
            default:
                next_state = ST_RATE;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state       <= ST_RATE;                      // see R01 R25
            rxState     <= RX_CMD;
            curCmd      <= 8'h00;
            remain      <= 8'h00;
            runSum      <= 8'h00;
            codeSr      <= 32'h00000000;
            lowCnt      <= 16'h0000;
            lowSeen     <= 1'b0;
            bitPeriod   <= 16'h0000;
            rateLocked  <= 1'b0;
            eraseStart  <= 1'b0;
            progMode    <= 1'b0;
            selDevice   <= 32'h00000000;
            devSelected <= 1'b0;
            replyLen    <= 4'd0;
            replyIdx    <= 4'd0;
            for (int i = 0; i < REPLY_LEN; i++)
                reply[i] <= 8'h00;
        end
        else
        begin
            state       <= next_state;
            rxState     <= next_rxState;
            curCmd      <= next_curCmd;
            remain      <= next_remain;
            runSum      <= next_runSum;
            codeSr      <= next_codeSr;
            lowCnt      <= next_lowCnt;
            lowSeen     <= next_lowSeen;
            bitPeriod   <= next_bitPeriod;
            rateLocked  <= next_rateLocked;
            eraseStart  <= next_eraseStart;
            progMode    <= next_progMode;
            selDevice   <= next_selDevice;
            devSelected <= next_devSelected;
            replyLen    <= next_replyLen;
            replyIdx    <= next_replyIdx;
            reply       <= next_reply;
        end
    end

    // ------------------------------------------------------------
    // transmit byte register
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            txByte <= '0;
        else
            txByte <= bufOut;
    end
endmodule : boot_cmd

// *** boot_cmd_pkg.sv ***
// Protocol rules; this block omits R05 loading and checks and R10 to R12
// R01: boot starts in bit-rate adjustment state
// R02: host sends zero byte; measure its low time
// R03: rate found, enter inquiry/selection state
// R04: transition command: erase arrays, enter program state
// R05: program state: load routines, sum/blank checks
// R06: packet bytes plus checksum sum to zero
// R07: size byte counts payload bytes only
// R08: inquiries and acknowledge are single bytes
// R09: error reply is response code plus error code
// R10: program data travels in 128-byte units
// R11: programming packet carries four-byte address first
// R12: memory read reply has four-byte size
// R13: device inquiry reply: 0x30, size, list, checksum
// R14: selection packet: 0x10, size 4, code, checksum
// R15: matching code adopted, acknowledge 0x06
// R16: selection error 0x90; codes 0x11, 0x21
// R17: host sends selections in fixed order
// R18: last of back-to-back selections wins
// R19: after transition only status inquiry valid
// R20: decode 0x21, 0x22, 0x23 inquiries
// R21: decode 0x24, 0x25, 0x26 inquiries
// R22: decode 0x27 unit inquiry, 0x3F rate selection
// R23: all exchanges over serial channel one
// R24: bad checksum command discarded, error reply only
// R25: commands before rate adjustment are ignored
package boot_cmd_pkg;
    localparam logic [7:0] CMD_DEV_INQ   = 8'h20;
    localparam logic [7:0] CMD_DEV_SEL   = 8'h10;
    localparam logic [7:0] CMD_CLK_INQ   = 8'h21;
    localparam logic [7:0] CMD_CLK_SEL   = 8'h11;
    localparam logic [7:0] CMD_DIV_INQ   = 8'h22;
    localparam logic [7:0] CMD_FRQ_INQ   = 8'h23;
    localparam logic [7:0] CMD_UBA_INQ   = 8'h24;
    localparam logic [7:0] CMD_UA_INQ    = 8'h25;
    localparam logic [7:0] CMD_BLK_INQ   = 8'h26;
    localparam logic [7:0] CMD_UNIT_INQ  = 8'h27;
    localparam logic [7:0] CMD_RATE_SEL  = 8'h3F;
    localparam logic [7:0] CMD_TRANS     = 8'h40;
    localparam logic [7:0] CMD_STAT_INQ  = 8'h4F;
    localparam logic [7:0] RSP_DEV_INQ   = 8'h30;
    localparam logic [7:0] RSP_ACK       = 8'h06;
    localparam logic [7:0] RSP_DEV_ERR   = 8'h90;
    localparam logic [7:0] ERR_SUM       = 8'h11;
    localparam logic [7:0] ERR_DEV       = 8'h21;
    localparam logic [7:0] SYNC_BYTE     = 8'h00;
    localparam logic [7:0] SEL_SIZE      = 8'h04;
    localparam logic [7:0] DEV_COUNT     = 8'h01;
    localparam logic [7:0] NAME_CHARS    = 8'h04;
    localparam int         UNIT_BYTES    = 128;   // see R10
    localparam int         ADDR_BYTES    = 4;     // see R11
    localparam int         RDSIZE_BYTES  = 4;     // see R12
    localparam int         SERIAL_CHAN   = 1;
    localparam int         CLK_MHZ       = 20;
    // supported device code, arbitrary value
    localparam logic [31:0] DEV_CODE     = 32'h41424344;
    // program name characters, arbitrary value
    localparam logic [31:0] PROG_NAME    = 32'h424F4F54;
    localparam logic [7:0]  INQ_SIZE     = 8'h0A;
    localparam int          REPLY_LEN    = 13;

    typedef enum logic [3:0] {
        ST_RATE = 4'b0001,
        ST_INQ  = 4'b0010,
        ST_ERAS = 4'b0100,
        ST_PROG = 4'b1000
    } boot_state_e;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } byte_s;

    function automatic logic [7:0] sum8(input logic [7:0] a,
                                        input logic [7:0] b);
        sum8 = a + b;
    endfunction : sum8
endpackage : boot_cmd_pkg

// *** byte_buffer.sv ***
`timescale 1ns/1ps
// two-entry buffer between reply builder and transmitter
module byte_buffer
(
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire boot_cmd_pkg::byte_s inByte,
    output logic                    inReady,
    output boot_cmd_pkg::byte_s     outByte,
    input  wire logic               outReady
);
    import boot_cmd_pkg::*;
    logic [7:0] mem [2];
    logic       wrPtr;
    logic       rdPtr;
    logic [1:0] count;
    logic       next_wrPtr;
    logic       next_rdPtr;
    logic [1:0] next_count;
    logic       doWr;
    logic       doRd;

    always_comb
    begin
        doWr       = inByte.valid && (count != 2'd2);
        doRd       = outReady && (count != 2'd0);
        next_wrPtr = wrPtr ^ doWr;
        next_rdPtr = rdPtr ^ doRd;
        next_count = count + {1'b0, doWr} - {1'b0, doRd};
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wrPtr <= 1'b0;
            rdPtr <= 1'b0;
            count <= 2'd0;
        end
        else
        begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
        if (doWr)
            mem[wrPtr] <= inByte.data;
    end

    assign inReady       = (count != 2'd2);
    assign outByte.valid = (count != 2'd0);
    assign outByte.data  = mem[rdPtr];
endmodule : byte_buffer

// *** boot_cmd_sva.sv ***
`timescale 1ns/1ps
// ------------------------------------
// boot command interpreter port checks
// ------------------------------------
module boot_cmd_sva
(
    input wire logic                clk,
    input wire logic                sys_rst,
    input wire logic                bootMode,
    input wire logic                serialRx,
    input wire boot_cmd_pkg::byte_s rxByte,
    input wire logic                txReady,
    input wire boot_cmd_pkg::byte_s txByte,
    input wire logic [15:0]         bitPeriod,
    input wire logic                rateLocked,
    input wire logic                eraseStart,
    input wire logic                eraseDone,
    input wire logic                progMode,
    input wire logic [31:0]         selDevice,
    input wire logic                devSelected
);
    import boot_cmd_pkg::*;
    logic seenErase;
    logic next_seenErase;
    always_comb next_seenErase = seenErase | eraseStart;
    always_ff @(posedge clk) seenErase <= sys_rst ? 1'b0 : next_seenErase;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_LOCK_HOLDS:
        assert property (rateLocked |=> rateLocked) else $error("lock lost");
    AST_PERIOD_SET:
        assert property ($rose(rateLocked) |-> bitPeriod != 16'h0000)
        else $error("lock without period");
    AST_NO_TX_UNLOCKED:
        assert property (!rateLocked |-> !txByte.valid)
        else $error("reply before lock");
    AST_SEL_NEEDS_LOCK:
        assert property (devSelected |-> rateLocked)
        else $error("selection before lock");
    AST_SEL_CODE:
        assert property (devSelected |-> selDevice == DEV_CODE)
        else $error("wrong adopted code");
    AST_ACK_ON_SEL:
        assert property ($rose(devSelected) |->
            ##[0:60] (txByte.valid && txByte.data == RSP_ACK))
        else $error("no acknowledge after selection");
    AST_ERASE_PULSE:
        assert property (eraseStart |=> !eraseStart)
        else $error("erase start too long");
    AST_ERASE_ORDER:
        assert property (eraseStart |-> rateLocked && !progMode)
        else $error("erase start out of state");
    AST_PROG_AFTER_ERASE:
        assert property ($rose(progMode) |-> seenErase)
        else $error("program state without erase");
    AST_PROG_HOLDS:
        assert property (progMode |=> progMode) else $error("program left");
    AST_SEL_FROZEN:
        assert property (progMode |=>
            $stable(selDevice) && $stable(devSelected))
        else $error("selection changed late");
endmodule : boot_cmd_sva

bind boot_cmd boot_cmd_sva i_boot_cmd_sva
(
    .clk(clk), .sys_rst(sys_rst), .bootMode(bootMode),
    .serialRx(serialRx), .rxByte(rxByte), .txReady(txReady),
    .txByte(txByte), .bitPeriod(bitPeriod), .rateLocked(rateLocked),
    .eraseStart(eraseStart), .eraseDone(eraseDone), .progMode(progMode),
    .selDevice(selDevice), .devSelected(devSelected)
);

// *** host_model.sv ***
`timescale 1ns/1ps
// -------------------------------
// host side of the serial channel
// -------------------------------
module host_model
(
    input  wire logic                clk,
    output logic                     serialRx,
    output boot_cmd_pkg::byte_s      rxByte,
    output logic                     txReady,
    input  wire boot_cmd_pkg::byte_s txByte
);
    import boot_cmd_pkg::*;
    logic [7:0] got[$];
    logic       stall;
    logic       lastReady;
    int         tick;
    initial
    begin
        serialRx = 1'b1;
        rxByte = '{valid: 1'b0, data: 8'hA5};
        txReady = 1'b1;
        stall = 1'b0;
        lastReady = 1'b0;
        tick = 0;
    end
    // slow receiver accepts one cycle in four while stalling
    always @(negedge clk)
    begin
        tick++;
        txReady = !stall || (tick % 4 == 0);
    end
    always @(posedge clk)
    begin
        if (txByte.valid && lastReady)
            got.push_back(txByte.data);
        lastReady = txReady;
    end
    // idle data shows the inverse of the last byte
    task automatic sendByte(input logic [7:0] b);
        @(negedge clk);
        rxByte = '{valid: 1'b1, data: b};
        @(negedge clk);
        rxByte = '{valid: 1'b0, data: ~b};
        repeat (3) @(negedge clk);
    endtask : sendByte
    task automatic sendPacket(input logic [7:0] p[$], input logic [7:0] skew);
        logic [7:0] sum;
        sum = 8'h00;
        foreach (p[i])
        begin
            sendByte(p[i]);
            sum = sum + p[i];
        end
        sendByte(8'h00 - sum + skew);
    endtask : sendPacket
    task automatic syncLow(input int n);
        @(negedge clk);
        serialRx = 1'b0;
        repeat (n) @(negedge clk);
        serialRx = 1'b1;
    endtask : syncLow
endmodule : host_model

// *** boot_cmd_tb.sv ***
`timescale 1ns/1ps
// -------------------------------
// boot command protocol testbench
// -------------------------------
module boot_cmd_tb;
    import boot_cmd_pkg::*;
    localparam int PERIOD = 10;
    logic        clk;
    logic        sys_rst;
    logic        bootMode;
    logic        serialRx;
    byte_s       rxByte;
    logic        txReady;
    byte_s       txByte;
    logic [15:0] bitPeriod;
    logic        rateLocked;
    logic        eraseStart;
    logic        eraseDone;
    logic        progMode;
    logic [31:0] selDevice;
    logic        devSelected;
    logic        eraseSeen;
    int          eraseCount;
    int          bad_count;
    int          compares;
    logic [7:0]  pkt[$];

    boot_cmd i_boot_cmd (.clk(clk), .sys_rst(sys_rst), .bootMode(bootMode),
        .serialRx(serialRx), .rxByte(rxByte), .txReady(txReady),
        .txByte(txByte), .bitPeriod(bitPeriod), .rateLocked(rateLocked),
        .eraseStart(eraseStart), .eraseDone(eraseDone),
        .progMode(progMode), .selDevice(selDevice),
        .devSelected(devSelected));
    host_model i_host_model (.clk(clk), .serialRx(serialRx),
        .rxByte(rxByte), .txReady(txReady), .txByte(txByte));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (eraseStart === 1'b1)
        begin
            eraseSeen = 1'b1;
            eraseCount++;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : check
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    task automatic waitSig(ref logic s, input string msg);
        int n;
        n = 0;
        while (s !== 1'b1)
        begin
            @(posedge clk);
            #1;
            n++;
            if (n > 2000)
            begin
                bad_count++;
                $display("BAD %0t %s timed out", $time, msg);
                conclude();
            end
        end
    endtask : waitSig
    task automatic expectBytes(input logic [7:0] e[$]);
        int n;
        n = 0;
        while (i_host_model.got.size() < e.size())
        begin
            @(posedge clk);
            n++;
            if (n > 2000)
            begin
                bad_count++;
                $display("BAD %0t reply too short", $time);
                conclude();
            end
        end
        foreach (e[i])
            check(i_host_model.got.pop_front(), e[i], "reply byte");
    endtask : expectBytes
    task automatic testEarly();
        i_host_model.sendByte(CMD_DEV_INQ);
        repeat (100) @(posedge clk);
        check(i_host_model.got.size(), 0, "early reply");
        check(rateLocked, 1'b0, "early lock");
        $display("early test done");
    endtask : testEarly
    task automatic testRate();
        i_host_model.syncLow(9 * PERIOD + 4);
        waitSig(rateLocked, "lock");
        check(bitPeriod, PERIOD, "bit period");
        check(progMode, 1'b0, "program state");
        $display("rate test done");
    endtask : testRate
    task automatic testInquiries();
        logic [7:0] codes[$];
        codes = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27};
        foreach (codes[i])
        begin
            i_host_model.sendByte(codes[i]);
            expectBytes('{RSP_ACK});
        end
        repeat (50) @(posedge clk);
        check(i_host_model.got.size(), 0, "extra reply");
        $display("inquiry test done");
    endtask : testInquiries
    task automatic testSelect();
        pkt = '{CMD_DEV_SEL, SEL_SIZE, DEV_CODE[31:24], DEV_CODE[23:16],
                DEV_CODE[15:8], DEV_CODE[7:0]};
        i_host_model.sendPacket(pkt, 8'h01);
        expectBytes('{RSP_DEV_ERR, ERR_SUM});
        check(devSelected, 1'b0, "bad sum adopted");
        pkt[5] = DEV_CODE[7:0] ^ 8'h01;
        i_host_model.sendPacket(pkt, 8'h00);
        expectBytes('{RSP_DEV_ERR, ERR_DEV});
        check(devSelected, 1'b0, "bad code adopted");
        pkt[5] = DEV_CODE[7:0];
        i_host_model.stall = 1'b1;
        i_host_model.sendPacket(pkt, 8'h00);
        expectBytes('{RSP_ACK});
        i_host_model.stall = 1'b0;
        check(selDevice, DEV_CODE, "adopted code");
        check(devSelected, 1'b1, "selected flag");
        i_host_model.sendPacket('{CMD_CLK_SEL, 8'h01, 8'h01}, 8'h00);
        expectBytes('{RSP_ACK});
        i_host_model.sendPacket('{CMD_RATE_SEL, 8'h01, 8'h01}, 8'h00);
        expectBytes('{RSP_ACK});
        check(selDevice, DEV_CODE, "code kept");
        $display("selection test done");
    endtask : testSelect
    task automatic testDevice();
        logic [7:0] e[$];
        logic [7:0] sum;
        e = '{RSP_DEV_INQ, 8'h00, DEV_COUNT, NAME_CHARS,
              DEV_CODE[31:24], DEV_CODE[23:16], DEV_CODE[15:8],
              DEV_CODE[7:0], PROG_NAME[31:24], PROG_NAME[23:16],
              PROG_NAME[15:8], PROG_NAME[7:0]};
        e[1] = 8'(e.size() - 2);
        sum = 8'h00;
        foreach (e[i])
            sum = sum + e[i];
        i_host_model.stall = 1'b1;
        i_host_model.sendByte(CMD_DEV_INQ);
        expectBytes(e);
        expectBytes('{8'h00 - sum});
        i_host_model.stall = 1'b0;
        $display("device inquiry test done");
    endtask : testDevice
    task automatic testTransit();
        i_host_model.sendByte(CMD_TRANS);
        waitSig(eraseSeen, "erase start");
        repeat (5) @(negedge clk);
        check(progMode, 1'b0, "program before erase");
        eraseDone = 1'b1;
        @(negedge clk);
        eraseDone = 1'b0;
        waitSig(progMode, "program state");
        check(eraseCount, 1, "erase count");
        repeat (100) @(posedge clk);
        i_host_model.got.delete();
        i_host_model.sendByte(CMD_DEV_INQ);
        repeat (100) @(posedge clk);
        check(i_host_model.got.size(), 0, "late inquiry");
        i_host_model.sendByte(CMD_STAT_INQ);
        expectBytes('{RSP_ACK});
        $display("transition test done");
    endtask : testTransit
    initial
    begin
        bad_count = 0;
        compares = 0;
        eraseCount = 0;
        eraseSeen = 1'b0;
        sys_rst = 1'b1;
        bootMode = 1'b1;
        eraseDone = 1'b0;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        check(progMode, 1'b0, "reset state");
        testEarly();
        testRate();
        testInquiries();
        testSelect();
        testDevice();
        testTransit();
        conclude();
    end
endmodule : boot_cmd_tb
